// ### ddsl_defs.svh
/*
 * Timing counts, word layout and address codes for the dual converter
 * serial load path. Assumes inclusion by bare name, once per unit.
 */
`ifndef DDSL_DEFS_SVH
`define DDSL_DEFS_SVH

// ==========================================================================
// Word layout
// ==========================================================================
`define DDSL_WORD_BITS      14
`define DDSL_CODE_BITS      12
`define DDSL_ADDR_HI_POS    13
`define DDSL_ADDR_LO_POS    12
`define DDSL_CODE_RESET     12'h000
// Link pins at rest, order strobe, select, data, clock: strobe and select high
`define DDSL_PIN_IDLE       4'hc

// ==========================================================================
// Address codes (hi, lo)
// ==========================================================================
`define DDSL_ADDR_CH_A      2'h2
`define DDSL_ADDR_CH_B      2'h3
`define DDSL_ADDR_BOTH      2'h0

// ==========================================================================
// Host timing: link clock half period, derived from the 100 ns clock
// ==========================================================================
`define DDSL_MCLK_NS        100
`define DDSL_HALF_NS        400
`define DDSL_HALF_CYC       ((`DDSL_HALF_NS + `DDSL_MCLK_NS - 1) / `DDSL_MCLK_NS)

`endif

// ### ddsl_pkg.sv
/*
 * Types shared by both ends of the serial load path.
 * Assumes ddsl_defs.svh sits in the same folder.
 */
`include "ddsl_defs.svh"

package ddsl_pkg;
    // ======================================================================
    // Types
    // ======================================================================
    typedef logic [`DDSL_CODE_BITS-1:0] ddsl_code_t;
    typedef logic [`DDSL_WORD_BITS-1:0] ddsl_word_t;

    typedef enum logic [2:0] {
        DDSL_IDLE   = 3'b000,
        DDSL_SELECT = 3'b001,
        DDSL_LOW    = 3'b010,
        DDSL_HIGH   = 3'b011,
        DDSL_DESEL  = 3'b100,
        DDSL_LOAD   = 3'b101
    } ddsl_state_e;
endpackage : ddsl_pkg

// ### ddsl_link_if.sv
/*
 * Four-wire serial link between the host end and the converter end.
 * Assumes both ends share nothing else; all wires one-way.
 */
`timescale 1ns/1ps

interface ddsl_link_if;
    logic serial_clk;
    logic serial_data_in;
    logic chip_sel_n;
    logic load_strobe_n;

    modport host (
        output serial_clk,
        output serial_data_in,
        output chip_sel_n,
        output load_strobe_n
    );
    modport dev (
        input  serial_clk,
        input  serial_data_in,
        input  chip_sel_n,
        input  load_strobe_n
    );
endinterface : ddsl_link_if

// ### ddsl_host.sv
/*
 * Host end: sends one 14-bit word per request, then pulses the load strobe.
 * Assumes a request only while o_busy is low; link clock made by a divider.
 */
`timescale 1ns/1ps
`include "ddsl_defs.svh"

module ddsl_host
    import ddsl_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    input  wire logic        i_req,
    input  wire logic [1:0]  i_addr,
    input  wire ddsl_code_t  i_code,
    output logic             o_busy,
    ddsl_link_if.host        link
);
    // ======================================================================
    // State
    // ======================================================================
    ddsl_state_e state_reg, state_next;
    ddsl_word_t  word_reg;
    logic [3:0]  bit_reg;
    logic [3:0]  div_reg;
    logic        sclk_reg, dout_reg, cs_n_reg, ld_n_reg, busy_reg;

    // Divider tick paces every phase of the link
    wire tick      = (div_reg == 4'(`DDSL_HALF_CYC - 1));
    wire last_bit  = (bit_reg == 4'(`DDSL_WORD_BITS - 1));
    wire take_req  = (state_reg == DDSL_IDLE) && i_req;

    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DDSL_IDLE:   if (i_req) state_next = DDSL_SELECT;
            DDSL_SELECT: if (tick) state_next = DDSL_LOW;
            DDSL_LOW:    if (tick) state_next = DDSL_HIGH;
            DDSL_HIGH:   if (tick) state_next = last_bit ? DDSL_DESEL : DDSL_LOW;
            DDSL_DESEL:  if (tick) state_next = DDSL_LOAD;
            DDSL_LOAD:   if (tick) state_next = DDSL_IDLE;
            default:     state_next = DDSL_IDLE;
        endcase
    end

    // Divider restarts at each phase so each phase lasts exactly one half period
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_reg <= 4'h0;
        end else if (state_reg == DDSL_IDLE || tick) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= DDSL_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Word: address pair first, then code MSB first
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            word_reg <= '0;
            bit_reg  <= 4'h0;
        end else if (take_req) begin
            word_reg <= {i_addr, i_code};
            bit_reg  <= 4'h0;
        end else if (state_reg == DDSL_HIGH && tick) begin
            word_reg <= {word_reg[`DDSL_WORD_BITS-2:0], 1'b0};
            bit_reg  <= bit_reg + 4'h1;
        end
    end

    // Pins: data changes on the falling half so it is stable at the rise.
    // Strobe only after deselect, and high again before the next word
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_reg <= 1'b0;
            dout_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            ld_n_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else begin
            sclk_reg <= (state_next == DDSL_HIGH);
            dout_reg <= word_reg[`DDSL_WORD_BITS-1];
            cs_n_reg <= !(state_next inside {DDSL_SELECT, DDSL_LOW, DDSL_HIGH});
            ld_n_reg <= (state_next != DDSL_LOAD);
            busy_reg <= (state_next != DDSL_IDLE);
        end
    end

    assign link.serial_clk     = sclk_reg;
    assign link.serial_data_in = dout_reg;
    assign link.chip_sel_n     = cs_n_reg;
    assign link.load_strobe_n  = ld_n_reg;
    assign o_busy              = busy_reg;
endmodule : ddsl_host

// ### ddsl_dev.sv
/*
 * Converter end: input shift register and two converter registers.
 * Assumes link pins are asynchronous to i_mclk; the link clock is sampled.
 */
`timescale 1ns/1ps
`include "ddsl_defs.svh"

// Operation
// - Each load word is exactly 14 bits
// - First two bits carry channel address
// - Then 12-bit code, MSB first
// - Code is straight binary, 000 to FFF
// - Shifting leaves converter registers unchanged
// - Load strobe falling copies word to channel
// - Strobe low: registers follow each shifted bit
// - Host raises strobe before next word
// - Chip select gates serial shifting
// - Shift on link clock rise, select low
// - Strobe low transparent regardless of select, clock
// - Host keeps select high while strobe low
module ddsl_dev
    import ddsl_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    ddsl_link_if.dev         link,
    output ddsl_code_t       o_code_a,
    output ddsl_code_t       o_code_b,
    output logic [3:0]       o_bit_count
);
    // ======================================================================
    // Synchronisers
    // ======================================================================
    // Pin order: clock, data, select, strobe. Reset matches the idle wires,
    // so no false edge or false load follows reset
    localparam int         NUM_PINS = 4;
    localparam logic [3:0] PIN_IDLE = `DDSL_PIN_IDLE;

    wire [NUM_PINS-1:0] pin_raw = {link.load_strobe_n, link.chip_sel_n, link.serial_data_in, link.serial_clk};
    wire [NUM_PINS-1:0] pin_s1;
    wire [NUM_PINS-1:0] pin_s2;

    // One three-stage chain per pin
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_sync
        logic [2:0] chain_reg;

        always_ff @(posedge i_mclk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                chain_reg <= {3{PIN_IDLE[p]}};
            end else begin
                chain_reg <= {chain_reg[1:0], pin_raw[p]};
            end
        end

        assign pin_s1[p] = chain_reg[1];
        assign pin_s2[p] = chain_reg[2];
    end

    // Stage 0 feeds stage 1 only; logic reads stages 1 and 2
    wire sclk_rise = pin_s1[0] && !pin_s2[0];
    wire data_bit  = pin_s1[1];
    wire cs_n      = pin_s1[2];
    wire ld_low    = !pin_s1[3];

    // ======================================================================
    // Shift register
    // ======================================================================
    ddsl_word_t shift_reg;
    logic [3:0] cnt_reg;
    wire        shift_en = sclk_rise && !cs_n;

    // Holds whenever no enabled rise arrives
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_reg <= '0;
            cnt_reg   <= 4'h0;
        end else if (shift_en) begin
            shift_reg <= {shift_reg[`DDSL_WORD_BITS-2:0], data_bit};
            cnt_reg   <= (cnt_reg == 4'(`DDSL_WORD_BITS - 1)) ? 4'h0 : cnt_reg + 4'h1;
        end
    end

    // ======================================================================
    // Address decode and converter registers
    // ======================================================================
    // Oldest two bits are the address
    wire addr_hi_bit = shift_reg[`DDSL_ADDR_HI_POS];
    wire addr_lo_bit = shift_reg[`DDSL_ADDR_LO_POS];
    wire hit_a       = !addr_hi_bit || !addr_lo_bit;
    wire hit_b       = !addr_hi_bit || addr_lo_bit;
    wire ddsl_code_t code_word = shift_reg[`DDSL_CODE_BITS-1:0];

    // Latches modelled as clocked followers: while the strobe is low the
    // addressed register tracks the shift register, so a falling edge loads
    // the word and later bits pass through
    localparam int NUM_CHAN = 2;

    wire [NUM_CHAN-1:0] hit = {hit_b, hit_a};
    wire ddsl_code_t    chan_code [NUM_CHAN];

    // One follower per channel, index 0 is channel A
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        ddsl_code_t code_reg;

        always_ff @(posedge i_mclk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                code_reg <= `DDSL_CODE_RESET;
            end else if (ld_low && hit[c]) begin
                code_reg <= code_word;
            end
        end

        assign chan_code[c] = code_reg;
    end

    // Codes pass unaltered as straight binary
    assign o_code_a    = chan_code[0];
    assign o_code_b    = chan_code[1];
    assign o_bit_count = cnt_reg;
endmodule : ddsl_dev

// ### ddsl_link_properties.sv
/* Wire assertions for the four-wire serial link.
   Assumes the host end drives every link pin from i_mclk. */
`timescale 1ns/1ps

module ddsl_link_properties (
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    input  wire logic serial_clk,
    input  wire logic serial_data_in,
    input  wire logic chip_sel_n,
    input  wire logic load_strobe_n
);
    // ======================================================================
    // Helper: link clock rises within one frame
    // ======================================================================
    logic [4:0] rises_reg;
    logic       clk_d_reg;

    // Cleared while deselected, so a stray frame cannot carry over
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rises_reg <= 5'h00;
            clk_d_reg <= 1'b0;
        end else begin
            clk_d_reg <= serial_clk;
            if (chip_sel_n) begin
                rises_reg <= 5'h00;
            end else if (serial_clk && !clk_d_reg) begin
                rises_reg <= rises_reg + 5'h01;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    // Bit cell: data held through the whole high half
    sequence s_bit_high;
        $rose(serial_clk) ##1 (serial_clk && $stable(serial_data_in)) [*3];
    endsequence
    // Load pulse: four cycles low, then high again
    sequence s_load_pulse;
        $fell(load_strobe_n) ##1 !load_strobe_n [*3] ##1 load_strobe_n;
    endsequence

    a_word_bits: assert property ($rose(chip_sel_n) |-> rises_reg == 5'h0e)
        else $error("frame did not hold fourteen bits");
    a_shift_selected: assert property ($rose(serial_clk) |-> !chip_sel_n)
        else $error("link clock rose while deselected");
    a_data_held: assert property ($rose(serial_clk) |-> s_bit_high)
        else $error("data moved during clock high");
    a_select_setup: assert property ($fell(chip_sel_n) |-> !serial_clk [*4])
        else $error("clock rose too soon after select");
    a_strobe_desel: assert property (!load_strobe_n |-> chip_sel_n)
        else $error("strobe low while selected");
    a_strobe_first: assert property ($fell(chip_sel_n) |-> load_strobe_n)
        else $error("frame began with strobe low");
    a_load_width: assert property ($fell(load_strobe_n) |-> s_load_pulse)
        else $error("load pulse width wrong");
    a_load_follows: assert property ($rose(chip_sel_n) |-> ##[1:8] s_load_pulse)
        else $error("no load pulse after frame");
endmodule : ddsl_link_properties

// ### dual_dac_serial_load_tb.sv
/* Testbench joining host and converter ends over the link.
   Assumes the host makes the link clock; outputs settle in 8 cycles. */
`timescale 1ns/1ps
`include "ddsl_defs.svh"
`define DDSL_CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %0t value mismatch", $time); end end

module dual_dac_serial_load_tb
    import ddsl_pkg::*;
();
    // ======================================================================
    // Signals and word table
    // ======================================================================
    logic       i_mclk = 1'b0;
    logic       i_arst_n;
    logic       i_req;
    logic [1:0] i_addr;
    ddsl_code_t i_code;
    logic       o_busy;
    ddsl_code_t o_code_a;
    ddsl_code_t o_code_b;
    logic [3:0] o_bit_count;
    ddsl_code_t exp_a;
    ddsl_code_t exp_b;
    ddsl_word_t wire_word;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles     = 0;
    logic [1:0] addr_tab [6] = '{`DDSL_ADDR_BOTH, `DDSL_ADDR_CH_A, `DDSL_ADDR_CH_B, 2'h1, 2'h2, 2'h3};
    ddsl_code_t code_tab [6] = '{12'h800, 12'hfff, 12'h000, 12'h7ff, 12'h801, 12'h001};

    ddsl_link_if i_ddsl_link_if ();
    ddsl_host i_ddsl_host (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(i_req), .i_addr(i_addr),
        .i_code(i_code), .o_busy(o_busy), .link(i_ddsl_link_if.host));
    ddsl_dev i_ddsl_dev (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(i_ddsl_link_if.dev),
        .o_code_a(o_code_a), .o_code_b(o_code_b), .o_bit_count(o_bit_count));
    ddsl_link_properties i_ddsl_link_properties (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .serial_clk(i_ddsl_link_if.serial_clk), .serial_data_in(i_ddsl_link_if.serial_data_in),
        .chip_sel_n(i_ddsl_link_if.chip_sel_n), .load_strobe_n(i_ddsl_link_if.load_strobe_n));

    always #50 i_mclk = ~i_mclk;

    // Own view of the wire, bits taken on each selected clock rise
    always @(posedge i_ddsl_link_if.serial_clk) begin
        if (!i_ddsl_link_if.chip_sel_n) wire_word <= {wire_word[12:0], i_ddsl_link_if.serial_data_in};
    end

    // Hang guard: six words need about 800 cycles
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // One word: request, mid-frame hold check, then result checks
    task automatic send(input logic [1:0] a, input ddsl_code_t c);
        int k;
        k = 0;
        @(negedge i_mclk);
        i_req  = 1'b1;
        i_addr = a;
        i_code = c;
        @(negedge i_mclk);
        i_req = 1'b0;
        repeat (60) @(negedge i_mclk);
        `DDSL_CHK(o_code_a, exp_a);
        `DDSL_CHK(o_code_b, exp_b);
        `DDSL_CHK(o_busy, 1'b1);
        while (o_busy !== 1'b0 && k < 300) begin
            @(negedge i_mclk);
            k++;
        end
        `DDSL_CHK(k < 300, 1'b1);
        if (!a[1]) begin
            exp_a = c;
            exp_b = c;
        end else if (!a[0]) exp_a = c;
        else exp_b = c;
        repeat (8) @(negedge i_mclk);
        `DDSL_CHK(wire_word, {a, c});
        `DDSL_CHK(o_code_a, exp_a);
        `DDSL_CHK(o_code_b, exp_b);
        `DDSL_CHK(o_bit_count, 4'h0);
    endtask : send

    // Reset, then the word table back to back
    initial begin
        i_arst_n = 1'b0;
        i_req    = 1'b0;
        i_addr   = 2'h0;
        i_code   = 12'h000;
        exp_a    = `DDSL_CODE_RESET;
        exp_b    = `DDSL_CODE_RESET;
        repeat (10) @(negedge i_mclk);
        i_arst_n = 1'b1;
        `DDSL_CHK(o_code_a, exp_a);
        `DDSL_CHK(o_code_b, exp_b);
        for (int i = 0; i < 6; i++) send(addr_tab[i], code_tab[i]);
        give_verdict();
    end
endmodule : dual_dac_serial_load_tb
